// [hw/diag_status_temp_flags.sv]
// Purpose: Die temperature register and diagnostic flag register with fail-silent
// Assumes: Serial frame logic hands over decoded reads, writes and frame errors
// Notes: All outputs registered; one clock, asynchronous active-high reset
`timescale 1ns/10ps
module diag_status_temp_flags #(
  parameter int OUTPUT_OK_FILTER_TIME_NS = 10000,
  parameter int GATE_STARTUP_TIME_NS = 1000000,
  parameter int THERMAL_SHUTDOWN_LIMIT_C = diag_pkg::THERMAL_SHUTDOWN_LIMIT_C
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic FRAME_ERROR,
  input wire logic CMD_NOT_ALLOWED,
  input wire logic OFF_MODE,
  input wire logic [7:0] TEMP_CODE,
  input wire logic OUT1_IN_WINDOW,
  input wire logic OUT2_IN_WINDOW,
  input wire logic GATE_SUPPLY_ENABLE,
  input wire logic GATE_IN_WINDOW,
  input wire logic SUPPLY_OV_DETECT,
  input wire logic SUPPLY_UV_DETECT,
  output logic REG_ACK,
  output logic [7:0] REG_RDATA,
  output logic [7:0] DIAG_FLAGS,
  output logic [7:0] DIE_TEMPERATURE,
  output logic FAIL_SILENT,
  output logic GATE_DRIVE_ALLOW
);

  localparam int FILTER_CYCLES = diag_pkg::ns_to_cycles(OUTPUT_OK_FILTER_TIME_NS);
  localparam int STARTUP_CYCLES = diag_pkg::ns_to_cycles(GATE_STARTUP_TIME_NS);
  localparam int SU_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [SU_W-1:0] SU_LIMIT = SU_W'(STARTUP_CYCLES);
  localparam logic [7:0] SHUTDOWN_CODE = diag_pkg::celsius_to_code(THERMAL_SHUTDOWN_LIMIT_C);

  // Die temperature register
  logic [7:0] die_temperature_reading;

  // Latched error flags
  logic overtemperature_flag;
  logic supply_undervoltage_flag;
  logic supply_overvoltage_flag;
  logic cmd_error_flag;
  logic gate_supply_error_flag;

  // Regulation flags
  logic output_one_regulated;
  logic output_two_regulated;
  logic gate_supply_regulated;

  logic fail_silent;
  logic off_mode_prev;
  diag_pkg::gate_state_e gate_state;
  diag_pkg::gate_state_e next_gate_state;
  logic [SU_W-1:0] startup_count;

  // Full seven-bit match, so no register aliases elsewhere in the map
  function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] target);
    addr_hit = addr == target;
  endfunction

  // Access decode
  // Off entry is the rising edge of the mode level, not the level itself
  wire off_entry = OFF_MODE && !off_mode_prev;
  wire hit_temp = addr_hit(REG_ADDR, diag_pkg::TEMP_ADDR);
  wire hit_diag = addr_hit(REG_ADDR, diag_pkg::DIAG_ADDR);
  // Write data is never stored; no bit here is writable
  wire access = REG_RD || REG_WR;
  // write to read-only location is disallowed
  wire write_read_only = REG_WR && hit_temp;
  wire bad_cmd = access && (FRAME_ERROR || CMD_NOT_ALLOWED || write_read_only);
  wire good_cmd = access && !bad_cmd;
  wire diag_write = good_cmd && REG_WR && hit_diag;
  wire clear_errors = diag_write || off_entry;

  // Unfiltered: one hot sample is enough to trip
  // code strictly above limit
  wire over_limit = TEMP_CODE > SHUTDOWN_CODE;

  // Gate supply sequencing decode
  wire startup_expired = startup_count == SU_LIMIT;
  wire gate_timeout = (gate_state == diag_pkg::GATE_STARTUP) && !GATE_IN_WINDOW
                      && startup_expired;
  wire gate_lost = (gate_state == diag_pkg::GATE_RUN) && !GATE_IN_WINDOW;
  wire gate_reached = (gate_state == diag_pkg::GATE_STARTUP) && GATE_IN_WINDOW;

  // Every error source but command errors feeds one latch; only Off entry releases it
  wire fault_event = SUPPLY_OV_DETECT || SUPPLY_UV_DETECT || over_limit
                     || gate_timeout || gate_lost;

  wire [7:0] diag_value = {output_one_regulated, output_two_regulated,
                           gate_supply_regulated, overtemperature_flag,
                           supply_undervoltage_flag, supply_overvoltage_flag,
                           cmd_error_flag, gate_supply_error_flag};

  // Write answers carry the content after the write takes effect
  // A flag set in the write cycle survives the clear, so it shows here too
  wire [4:0] low_after_write = {over_limit, SUPPLY_UV_DETECT, SUPPLY_OV_DETECT, 1'b0,
                                gate_timeout};
  wire [7:0] diag_after_write = {output_one_regulated, output_two_regulated,
                                 gate_supply_regulated, low_after_write};
  // Unmapped addresses answer zero and are not errors
  wire [7:0] read_value = hit_temp ? die_temperature_reading :
                          hit_diag ? (REG_WR ? diag_after_write : diag_value) :
                          diag_pkg::UNMAPPED_DATA;
  // Discarded commands answer zero in the data field
  wire [7:0] next_rdata = bad_cmd ? diag_pkg::UNMAPPED_DATA : read_value;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      die_temperature_reading <= diag_pkg::TEMP_RESET;
    end else begin
      die_temperature_reading <= TEMP_CODE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      off_mode_prev <= 1'b0;
    end else begin
      off_mode_prev <= OFF_MODE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      supply_overvoltage_flag <= 1'b0;
    end else if (SUPPLY_OV_DETECT) begin
      supply_overvoltage_flag <= 1'b1;
    end else if (clear_errors) begin
      supply_overvoltage_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      supply_undervoltage_flag <= 1'b0;
    end else if (SUPPLY_UV_DETECT) begin
      supply_undervoltage_flag <= 1'b1;
    end else if (clear_errors) begin
      supply_undervoltage_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      overtemperature_flag <= 1'b0;
    end else if (over_limit) begin
      overtemperature_flag <= 1'b1;
    end else if (clear_errors) begin
      overtemperature_flag <= 1'b0;
    end
  end

  // set on bad, clear on good
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmd_error_flag <= 1'b0;
    end else if (bad_cmd) begin
      cmd_error_flag <= 1'b1;
    end else if (good_cmd || off_entry) begin
      cmd_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      gate_supply_error_flag <= 1'b0;
    end else if (gate_timeout) begin
      gate_supply_error_flag <= 1'b1;
    end else if (clear_errors) begin
      gate_supply_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      fail_silent <= 1'b0;
    end else if (fault_event) begin
      fail_silent <= 1'b1;
    end else if (off_entry) begin
      fail_silent <= 1'b0;
    end
  end

  // Gate supply sequencer
  always_comb begin
    next_gate_state = gate_state;
    case (gate_state)
      diag_pkg::GATE_OFF: begin
        if (GATE_SUPPLY_ENABLE && !fail_silent && !OFF_MODE) begin
          next_gate_state = diag_pkg::GATE_STARTUP;
        end
      end
      diag_pkg::GATE_STARTUP: begin
        if (gate_reached) begin
          next_gate_state = diag_pkg::GATE_RUN;
        end else if (gate_timeout) begin
          next_gate_state = diag_pkg::GATE_FAULT;
        end
      end
      diag_pkg::GATE_RUN: begin
        if (gate_lost) begin
          next_gate_state = diag_pkg::GATE_FAULT;
        end
      end
      diag_pkg::GATE_FAULT: begin
        next_gate_state = diag_pkg::GATE_FAULT;
      end
      default: begin
        next_gate_state = diag_pkg::GATE_OFF;
      end
    endcase
    // Disable and Off both drop the supply; a fault waits for Off
    if (off_entry || OFF_MODE) begin
      next_gate_state = diag_pkg::GATE_OFF;
    end else if (!GATE_SUPPLY_ENABLE && gate_state != diag_pkg::GATE_FAULT) begin
      next_gate_state = diag_pkg::GATE_OFF;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      gate_state <= diag_pkg::GATE_OFF;
    end else begin
      gate_state <= next_gate_state;
    end
  end

  // Saturates, so a stuck start-up holds the timeout instead of wrapping
  // start-up timer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      startup_count <= '0;
    end else if (gate_state != diag_pkg::GATE_STARTUP) begin
      startup_count <= '0;
    end else if (!startup_expired) begin
      startup_count <= startup_count + SU_W'(1);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      gate_supply_regulated <= 1'b0;
    end else begin
      gate_supply_regulated <= next_gate_state == diag_pkg::GATE_RUN;
    end
  end

  // Ok flags track the outputs and are not part of the Off clear
  // filtered output ok flags
  level_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) out1_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .clear(1'b0),
    .level_in(OUT1_IN_WINDOW),
    .flag(output_one_regulated)
  );

  level_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) out2_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .clear(1'b0),
    .level_in(OUT2_IN_WINDOW),
    .flag(output_two_regulated)
  );

  // Answer strobe one cycle after the request, refused ones included
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_ACK <= 1'b0;
    end else begin
      REG_ACK <= access;
    end
  end

  // Answer data holds until the next request
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= diag_pkg::UNMAPPED_DATA;
    end else if (access) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Mirrors follow the registers by one cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DIAG_FLAGS <= diag_pkg::DIAG_RESET;
    end else begin
      DIAG_FLAGS <= diag_value;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DIE_TEMPERATURE <= diag_pkg::TEMP_RESET;
    end else begin
      DIE_TEMPERATURE <= die_temperature_reading;
    end
  end

  // Status copy only; the drive enable below does not wait for it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FAIL_SILENT <= 1'b0;
    end else begin
      FAIL_SILENT <= fail_silent;
    end
  end

  // Fault event read directly so switching stops at the edge that latches it
  // switching only when ok and not silent
  wire next_drive_allow = gate_supply_regulated && !fail_silent && !fault_event;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      GATE_DRIVE_ALLOW <= 1'b0;
    end else begin
      GATE_DRIVE_ALLOW <= next_drive_allow;
    end
  end

endmodule // diag_status_temp_flags

// [hw/diag_pkg.sv]
// Purpose: Constants for the die temperature and diagnostic flag block
// Assumes: Register access arrives as decoded strobes from the serial frame logic
package diag_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [6:0] TEMP_ADDR = 7'h46;
  localparam logic [6:0] DIAG_ADDR = 7'h5F;

  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  localparam int BIT_OUT1_OK = 7;
  localparam int BIT_OUT2_OK = 6;
  localparam int BIT_GATE_OK = 5;
  localparam int BIT_OVERTEMP = 4;
  localparam int BIT_UNDERVOLT = 3;
  localparam int BIT_OVERVOLT = 2;
  localparam int BIT_CMD_ERR = 1;
  localparam int BIT_GATE_ERR = 0;

  // Temperature code mapping
  localparam int TEMP_SCALE_NUM = 215;
  localparam int TEMP_SCALE_DEN = 106;
  localparam int TEMP_OFFSET_C = 88;
  localparam logic [7:0] TEMP_CODE_LOW = 8'h18;
  localparam logic [7:0] TEMP_CODE_HIGH = 8'h82;
  localparam int THERMAL_SHUTDOWN_LIMIT_C = 175;

  localparam int CLK_PERIOD_NS = 100;

  typedef enum logic [1:0] {
    GATE_OFF = 2'b00,
    GATE_STARTUP = 2'b01,
    GATE_RUN = 2'b10,
    GATE_FAULT = 2'b11
  } gate_state_e;

  // Smallest code whose temperature reaches the given Celsius value
  function automatic logic [7:0] celsius_to_code(input int celsius);
    int num;
    num = (celsius + TEMP_OFFSET_C) * TEMP_SCALE_DEN;
    celsius_to_code = 8'((num + TEMP_SCALE_NUM - 1) / TEMP_SCALE_NUM);
  endfunction

  // Least cycles covering a time, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ns_to_cycles = (c < 1) ? 1 : c;
  endfunction

endpackage

// [hw/level_filter.sv]
// Purpose: Holds a flag until its input has stood in the other state long enough
// Assumes: Input synchronous to the clock
// Notes: Flag resets to 0
`timescale 1ns/10ps
module level_filter #(
  parameter int FILTER_CYCLES = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic level_in,
  output logic flag
);

  localparam int CNT_W = $clog2(FILTER_CYCLES + 2);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(FILTER_CYCLES);

  logic [CNT_W-1:0] count;
  wire differs = level_in != flag;
  wire expired = differs && (count == CNT_LIMIT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear || !differs || expired) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (clear) begin
      flag <= 1'b0;
    end else if (expired) begin
      flag <= level_in;
    end
  end

endmodule // level_filter

// [dv/diag_status_temp_flags_checker.sv]
// Purpose: Port checks for the diagnostic flag block
// Assumes: One clock, reset active high
// Notes: Bound after the module
`timescale 1ns/10ps
module diag_status_temp_flags_checker #(
  parameter int OUTPUT_OK_FILTER_TIME_NS = 10000
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [6:0] REG_ADDR,
  input wire logic FRAME_ERROR,
  input wire logic CMD_NOT_ALLOWED,
  input wire logic OFF_MODE,
  input wire logic [7:0] TEMP_CODE,
  input wire logic OUT1_IN_WINDOW,
  input wire logic SUPPLY_OV_DETECT,
  input wire logic SUPPLY_UV_DETECT,
  input wire logic REG_ACK,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] DIAG_FLAGS,
  input wire logic [7:0] DIE_TEMPERATURE,
  input wire logic FAIL_SILENT,
  input wire logic GATE_DRIVE_ALLOW
);
  localparam logic [15:0] FILT = 16'(OUTPUT_OK_FILTER_TIME_NS / 100);
  logic [15:0] in_run;
  wire good = !FRAME_ERROR && !CMD_NOT_ALLOWED;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Run length kept wide; short runs never wrap
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      in_run <= 16'h0000;
    end else begin
      in_run <= OUT1_IN_WINDOW ? in_run + 16'h0001 : 16'h0000;
    end
  end
  ack_follows_req_a: assert property ((REG_RD || REG_WR) |=> REG_ACK)
    else $error("ack missing");
  no_stray_ack_a: assert property (REG_ACK |-> $past(REG_RD || REG_WR))
    else $error("ack without request");
  temp_read_a: assert property ((REG_RD && good && REG_ADDR == 7'h46) |=>
    REG_RDATA == DIE_TEMPERATURE) else $error("temperature read wrong");
  temp_copy_a: assert property ((!$past(RST) && !$past(RST, 2)) |->
    DIE_TEMPERATURE == $past(TEMP_CODE, 2)) else $error("temperature lag wrong");
  ov_flag_a: assert property (SUPPLY_OV_DETECT |-> ##2 (DIAG_FLAGS[2] && FAIL_SILENT))
    else $error("overvoltage not latched");
  uv_flag_a: assert property (SUPPLY_UV_DETECT |=> ##1 DIAG_FLAGS[3])
    else $error("undervoltage not latched");
  overtemp_flag_a: assert property ((TEMP_CODE > 8'h82) |-> ##[2:3] DIAG_FLAGS[4])
    else $error("overtemperature not latched");
  write_clear_a: assert property ((REG_WR && good && REG_ADDR == 7'h5F &&
    !SUPPLY_OV_DETECT && !SUPPLY_UV_DETECT) |=> (REG_RDATA[3:1] == 3'b000) ##1
    (DIAG_FLAGS[3:1] == 3'b000)) else $error("write did not clear");
  silent_sticky_a: assert property ((FAIL_SILENT && !OFF_MODE && !$past(OFF_MODE))
    |=> FAIL_SILENT) else $error("fail-silent released");
  silent_no_drive_a: assert property (FAIL_SILENT |-> !GATE_DRIVE_ALLOW)
    else $error("drive while silent");
  out_filter_a: assert property ($rose(DIAG_FLAGS[7]) |-> in_run >= FILT)
    else $error("output ok set early");
  cover property (REG_WR && !good);
  cover property ($rose(FAIL_SILENT));
  cover property ($rose(GATE_DRIVE_ALLOW));
endmodule // diag_status_temp_flags_checker

bind diag_status_temp_flags diag_status_temp_flags_checker #(
  .OUTPUT_OK_FILTER_TIME_NS(OUTPUT_OK_FILTER_TIME_NS)
) i_diag_status_temp_flags_checker (
  .SYS_CLK(SYS_CLK), .RST(RST), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .FRAME_ERROR(FRAME_ERROR), .CMD_NOT_ALLOWED(CMD_NOT_ALLOWED), .OFF_MODE(OFF_MODE),
  .TEMP_CODE(TEMP_CODE), .OUT1_IN_WINDOW(OUT1_IN_WINDOW), .REG_ACK(REG_ACK),
  .SUPPLY_OV_DETECT(SUPPLY_OV_DETECT), .SUPPLY_UV_DETECT(SUPPLY_UV_DETECT),
  .REG_RDATA(REG_RDATA), .DIAG_FLAGS(DIAG_FLAGS), .DIE_TEMPERATURE(DIE_TEMPERATURE),
  .FAIL_SILENT(FAIL_SILENT), .GATE_DRIVE_ALLOW(GATE_DRIVE_ALLOW)
);

// [dv/mcu_model.sv]
// Purpose: Controller side issuing register commands
// Assumes: Strobes are one-cycle pulses
// Notes: Released address and data lines show inverted values; strobes and error lines return to 0
`timescale 1ns/10ps
module mcu_model (
  input wire logic sys_clk,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  output logic reg_rd,
  output logic reg_wr,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic frame_error,
  output logic cmd_not_allowed
);
  initial begin
    {reg_rd, reg_wr, frame_error, cmd_not_allowed} = 4'h0;
    {reg_addr, reg_wdata} = 15'h0000;
  end
  // Bounded wait; a dead ack must not hang the run
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
      input logic [1:0] bad, output logic [7:0] q, output logic ok);
    @(negedge sys_clk);
    {reg_rd, reg_wr, reg_addr, reg_wdata, frame_error, cmd_not_allowed} = {!w, w, a, d, bad};
    ok = 1'b0;
    q = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge sys_clk);
      {reg_rd, reg_wr, reg_addr, reg_wdata, frame_error, cmd_not_allowed} = {2'b00, ~a, ~d, 2'b00};
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        q = reg_rdata;
      end
    end
  endtask
endmodule // mcu_model

// [dv/diag_status_temp_flags_test.sv]
// Purpose: Self-checking bench for the diagnostic flag block
// Assumes: Short filter and start-up times by parameter
// Notes: Inputs change on the falling edge
`timescale 1ns/10ps
module diag_status_temp_flags_test;
  logic sys_clk, rst, off_mode, out1_win, out2_win, gate_en, gate_win, ov_det, uv_det;
  logic rd, wr, frame_err, cmd_bad, ack, fail_silent, drive_allow;
  logic [6:0] addr;
  logic [7:0] wdata, temp_code, rdata, diag_flags, die_temp;
  logic [7:0] codes [3] = '{8'h18, 8'h82, 8'h83};
  int miscompares, num_checks;

  diag_status_temp_flags #(
    .OUTPUT_OK_FILTER_TIME_NS(500),
    .GATE_STARTUP_TIME_NS(1000)
  ) i_diag_status_temp_flags (
    .SYS_CLK(sys_clk), .RST(rst), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wdata), .FRAME_ERROR(frame_err), .CMD_NOT_ALLOWED(cmd_bad),
    .OFF_MODE(off_mode), .TEMP_CODE(temp_code), .OUT1_IN_WINDOW(out1_win),
    .OUT2_IN_WINDOW(out2_win), .GATE_SUPPLY_ENABLE(gate_en), .GATE_IN_WINDOW(gate_win),
    .SUPPLY_OV_DETECT(ov_det), .SUPPLY_UV_DETECT(uv_det), .REG_ACK(ack),
    .REG_RDATA(rdata), .DIAG_FLAGS(diag_flags), .DIE_TEMPERATURE(die_temp),
    .FAIL_SILENT(fail_silent), .GATE_DRIVE_ALLOW(drive_allow)
  );

  mcu_model i_mcu_model (
    .sys_clk(sys_clk), .reg_ack(ack), .reg_rdata(rdata), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .frame_error(frame_err), .cmd_not_allowed(cmd_bad)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic acc(input logic w, input logic [6:0] a, input logic [1:0] bad,
      input logic [7:0] exp, input string what);
    logic [7:0] got;
    logic ok;
    i_mcu_model.access(w, a, 8'h5A, bad, got, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD ack expected 1 seen %b", ok);
      complete_run();
    end else begin
      chk8(what, exp, got);
    end
  endtask

  // Off pulse held long enough for the level to be seen as an entry
  task automatic off_entry();
    off_mode = 1'b1;
    tick(4);
    off_mode = 1'b0;
    tick(2);
    chk1("silent after off", 1'b0, fail_silent);
    chk8("flags after off", 8'h00, {3'h0, diag_flags[4:0]});
  endtask

  initial begin
    rst = 1'b1;
    {off_mode, out1_win, out2_win, gate_en, gate_win, ov_det, uv_det} = 7'h00;
    temp_code = 8'h40;
    miscompares = 0;
    num_checks = 0;
    tick(6);
    rst = 1'b0;
    acc(1'b1, diag_pkg::DIAG_ADDR, 2'b00, 8'h00, "start clear");
    acc(1'b0, diag_pkg::DIAG_ADDR, 2'b00, diag_pkg::DIAG_RESET, "diag reset");
    acc(1'b0, 7'h10, 2'b00, 8'h00, "unmapped");
    foreach (codes[k]) begin
      temp_code = codes[k];
      tick(4);
      acc(1'b0, diag_pkg::TEMP_ADDR, 2'b00, codes[k], "temperature");
      chk8("temp mirror", codes[k], die_temp);
      chk1("overtemp", (int'(codes[k]) * 215 / 106 - 88) > 175, diag_flags[4]);
    end
    chk1("hot silent", 1'b1, fail_silent);
    temp_code = 8'h40;
    tick(3);
    acc(1'b1, diag_pkg::DIAG_ADDR, 2'b00, 8'h00, "hot clear");
    chk1("silent held", 1'b1, fail_silent);
    off_entry();
    for (int k = 0; k < 3; k++) begin
      acc(k == 2, (k == 2) ? diag_pkg::TEMP_ADDR : diag_pkg::DIAG_ADDR,
          (k == 2) ? 2'b00 : 2'(k + 1), 8'h00, "refused");
    end
    acc(1'b0, diag_pkg::DIAG_ADDR, 2'b00, 8'h02, "cmd error");
    acc(1'b0, diag_pkg::DIAG_ADDR, 2'b00, 8'h00, "cmd good");
    for (int k = 0; k < 2; k++) begin
      {ov_det, uv_det} = (k == 0) ? 2'b10 : 2'b01;
      tick(1);
      {ov_det, uv_det} = 2'b00;
      tick(3);
      acc(1'b0, diag_pkg::DIAG_ADDR, 2'b00, (k == 0) ? 8'h04 : 8'h08, "supply");
      chk1("supply silent", 1'b1, fail_silent);
      acc(1'b1, diag_pkg::DIAG_ADDR, 2'b00, 8'h00, "supply clear");
      chk1("supply held", 1'b1, fail_silent);
      off_entry();
    end
    for (int k = 0; k < 2; k++) begin
      {out1_win, out2_win} = (k == 0) ? 2'b10 : 2'b01;
      tick(3);
      {out1_win, out2_win} = 2'b00;
      tick(3);
      chk1("short window", 1'b0, diag_flags[7 - k]);
      {out1_win, out2_win} = (k == 0) ? 2'b10 : 2'b01;
      tick(10);
      chk1("regulated", 1'b1, diag_flags[7 - k]);
      {out1_win, out2_win} = 2'b00;
      tick(3);
      chk1("short dropout", 1'b1, diag_flags[7 - k]);
      tick(10);
      chk1("deviating", 1'b0, diag_flags[7 - k]);
    end
    {gate_en, gate_win} = 2'b11;
    tick(4);
    chk1("gate ok", 1'b1, diag_flags[5]);
    chk1("drive on", 1'b1, drive_allow);
    gate_win = 1'b0;
    tick(3);
    chk1("gate lost", 1'b0, diag_flags[5]);
    chk1("drive off", 1'b0, drive_allow);
    chk1("gate silent", 1'b1, fail_silent);
    gate_en = 1'b0;
    off_entry();
    gate_en = 1'b1;
    tick(16);
    chk1("start-up error", 1'b1, diag_flags[0]);
    chk1("start-up silent", 1'b1, fail_silent);
    gate_en = 1'b0;
    off_entry();
    acc(1'b0, diag_pkg::DIAG_ADDR, 2'b00, 8'h00, "after off");
    complete_run();
  end
endmodule // diag_status_temp_flags_test
